// file: pkg/mmcp_params.svh
// constants for the modem mode and configuration parser
`ifndef MMCP_PARAMS_SVH
`define MMCP_PARAMS_SVH
// ==========================================================
// clock and serial rates
`define MMCP_CLK_HZ 10000000
`define MMCP_CLK_MHZ 10
`define MMCP_BAUD0 1200
`define MMCP_BAUD1 2400
`define MMCP_BAUD2 4800
`define MMCP_BAUD3 9600
`define MMCP_BAUD4 19200
`define MMCP_BAUD5 38400
`define MMCP_BAUD6 57600
`define MMCP_BAUD7 115200
`define MMCP_CFG_RATE 3'h3
`define MMCP_WAKE_TIME_US 1000
// ==========================================================
// command framing bytes
`define MMCP_HDR_WRITE 8'hc0
`define MMCP_HDR_READ 8'hc1
`define MMCP_HDR_TEMP 8'hc2
`define MMCP_HDR_WRAP 8'hcf
`define MMCP_HDR_ERR 8'hff
`define MMCP_WRAP_LEN 4'h2
`define MMCP_HEAD_LEN 4'h3
// ==========================================================
// configuration register file
`define MMCP_REG_COUNT 8
`define MMCP_REG_LIMIT 9'h008
`define MMCP_RATE_IDX 3'h3
`define MMCP_RATE_RESET 8'h60
`define MMCP_RATE_MSB 7
`define MMCP_RATE_LSB 5
// ==========================================================
// wishbone map
`define MMCP_WB_STATUS 6'h20
`define MMCP_WB_CTRL 6'h24
`define MMCP_CTRL_SENDER 0
`endif

// file: pkg/mmcp_pkg.sv
// types shared by the modem mode and configuration parser
package mmcp_pkg;
  // ==========================================================
  // operating modes in mode-select order {high, low}
  typedef enum logic [1:0] {
    mode_transparent,
    mode_wor,
    mode_config,
    mode_sleep
  } mmcp_mode_type;
  // ==========================================================
  // command parser states
  typedef enum logic [2:0] {
    st_idle,
    st_wrap2,
    st_addr,
    st_len,
    st_param,
    st_reply
  } mmcp_state_type;
endpackage : mmcp_pkg

// file: logic/mmcp_top.sv
// mode selector, serial relay and configuration command parser
`include "mmcp_params.svh"
module mmcp_top
  import mmcp_pkg::*;
#(
  parameter int WAKE_CYCLES = `MMCP_WAKE_TIME_US * `MMCP_CLK_MHZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // mode select lines, high is active
  input wire logic mode_select_low,
  input wire logic mode_select_high,
  // host serial link
  input wire logic host_rxd,
  output logic host_txd,
  // radio transmit path
  output logic [7:0] radio_tx_data,
  output logic radio_tx_valid,
  input wire logic radio_tx_ready,
  output logic radio_tx_preamble,
  // radio receive path
  input wire logic [7:0] radio_rx_data,
  input wire logic radio_rx_valid,
  output logic radio_rx_ready,
  output logic radio_rx_enable,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  // ==========================================================
  // mode decode
  mmcp_mode_type mode;
  logic data_mode;
  logic cfg_mode;
  assign mode = mmcp_mode_type'({mode_select_high, mode_select_low});
  assign data_mode = (mode == mode_transparent) || (mode == mode_wor);
  assign cfg_mode = (mode == mode_config);
  assign radio_rx_enable = (mode != mode_sleep);

  // ==========================================================
  // register file and control
  logic [7:0] cfg_reg [`MMCP_REG_COUNT];
  logic sender_reg;
  logic [15:0] baud_div;

  // clock divisor for one serial bit
  function automatic logic [15:0] div_of(input logic [2:0] code);
    case (code)
      3'h0: div_of = 16'(`MMCP_CLK_HZ / `MMCP_BAUD0);
      3'h1: div_of = 16'(`MMCP_CLK_HZ / `MMCP_BAUD1);
      3'h2: div_of = 16'(`MMCP_CLK_HZ / `MMCP_BAUD2);
      3'h3: div_of = 16'(`MMCP_CLK_HZ / `MMCP_BAUD3);
      3'h4: div_of = 16'(`MMCP_CLK_HZ / `MMCP_BAUD4);
      3'h5: div_of = 16'(`MMCP_CLK_HZ / `MMCP_BAUD5);
      3'h6: div_of = 16'(`MMCP_CLK_HZ / `MMCP_BAUD6);
      default: div_of = 16'(`MMCP_CLK_HZ / `MMCP_BAUD7);
    endcase
  endfunction : div_of

  // configuration always runs at the fixed command rate
  assign baud_div = cfg_mode ? div_of(`MMCP_CFG_RATE) :
      div_of(cfg_reg[`MMCP_RATE_IDX][`MMCP_RATE_MSB:`MMCP_RATE_LSB]);

  // ==========================================================
  // serial receiver, sampled mid-bit
  logic [15:0] rx_cnt_reg;
  logic [3:0] rx_bit_reg;
  logic [7:0] rx_shift_reg;
  logic [7:0] rx_byte_reg;
  logic rx_busy_reg;
  logic rx_valid_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_cnt_reg <= 16'h0000;
      rx_bit_reg <= 4'h0;
      rx_shift_reg <= 8'h00;
      rx_byte_reg <= 8'h00;
      rx_busy_reg <= 1'b0;
      rx_valid_reg <= 1'b0;
    end else begin
      rx_valid_reg <= 1'b0;
      if (!rx_busy_reg) begin
        if (!host_rxd) begin
          rx_busy_reg <= 1'b1;
          rx_cnt_reg <= baud_div >> 1;
          rx_bit_reg <= 4'h0;
        end
      end else if (rx_cnt_reg != 16'h0000) begin
        rx_cnt_reg <= rx_cnt_reg - 16'h0001;
      end else begin
        rx_cnt_reg <= baud_div - 16'h0001;
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_bit_reg == 4'h0) begin
          if (host_rxd) rx_busy_reg <= 1'b0; // false start
        end else if (rx_bit_reg == 4'h9) begin
          rx_busy_reg <= 1'b0;
          if (host_rxd) begin // good stop bit, 8N1
            rx_valid_reg <= 1'b1;
            rx_byte_reg <= rx_shift_reg;
          end
        end else begin
          rx_shift_reg <= {host_rxd, rx_shift_reg[7:1]};
        end
      end
    end
  end

  // ==========================================================
  // serial transmitter
  logic [9:0] tx_shift_reg;
  logic [15:0] tx_cnt_reg;
  logic [3:0] tx_bit_reg;
  logic tx_busy_reg;
  logic tx_load;
  logic [7:0] tx_byte;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_shift_reg <= 10'h3ff;
      tx_cnt_reg <= 16'h0000;
      tx_bit_reg <= 4'h0;
      tx_busy_reg <= 1'b0;
      host_txd <= 1'b1;
    end else if (tx_load) begin
      tx_shift_reg <= {1'b1, tx_byte, 1'b0};
      tx_cnt_reg <= 16'h0000;
      tx_bit_reg <= 4'h0;
      tx_busy_reg <= 1'b1;
    end else if (tx_busy_reg) begin
      if (tx_cnt_reg != 16'h0000) begin
        tx_cnt_reg <= tx_cnt_reg - 16'h0001;
      end else if (tx_bit_reg == 4'ha) begin
        tx_busy_reg <= 1'b0;
      end else begin
        host_txd <= tx_shift_reg[0];
        tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
        tx_cnt_reg <= baud_div - 16'h0001;
        tx_bit_reg <= tx_bit_reg + 4'h1;
      end
    end
  end

  // ==========================================================
  // command parser state
  mmcp_state_type state_reg;
  logic wrap_reg;
  logic err_reg;
  logic src_radio_reg;
  logic [7:0] cmd_reg;
  logic [7:0] addr_reg;
  logic [7:0] len_reg;
  logic [7:0] idx_reg;
  logic [3:0] out_idx_reg;
  logic frame_free;
  logic serial_in;
  logic radio_in;
  logic p_valid;
  logic [7:0] p_byte;
  logic [8:0] end_addr;

  assign frame_free = (state_reg == st_idle) && !wrap_reg;
  assign serial_in = cfg_mode && rx_valid_reg && (frame_free || !src_radio_reg);
  assign radio_in = cfg_mode && radio_rx_valid && radio_rx_ready;
  assign p_valid = serial_in || radio_in;
  assign p_byte = serial_in ? rx_byte_reg : radio_rx_data;
  assign end_addr = {1'b0, addr_reg} + {1'b0, p_byte};

  // ==========================================================
  // reply byte generator
  logic [3:0] pre_len;
  logic [3:0] out_total;
  logic [3:0] out_pos;
  logic [2:0] rd_idx;
  logic [7:0] reply_byte;
  logic rt_valid_reg;
  logic dest_ready;
  logic reply_fire;

  assign pre_len = wrap_reg ? `MMCP_WRAP_LEN : 4'h0;
  assign out_total = pre_len + `MMCP_HEAD_LEN + (err_reg ? 4'h0 : len_reg[3:0]);
  assign out_pos = out_idx_reg - pre_len;
  assign rd_idx = 3'(addr_reg[2:0] + out_pos[2:0] - 3'h3);

  // byte at the current reply position
  always_comb begin
    if (out_idx_reg < pre_len) begin
      reply_byte = `MMCP_HDR_WRAP;
    end else if (err_reg) begin
      reply_byte = `MMCP_HDR_ERR;
    end else begin
      case (out_pos)
        4'h0: reply_byte = `MMCP_HDR_READ;
        4'h1: reply_byte = addr_reg;
        4'h2: reply_byte = len_reg;
        default: reply_byte = cfg_reg[rd_idx];
      endcase
    end
  end

  // reply follows the path of the command
  assign dest_ready = src_radio_reg ? !rt_valid_reg : !tx_busy_reg;
  assign reply_fire = cfg_mode && (state_reg == st_reply) && dest_ready;

  // parser sequencing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= st_idle;
      wrap_reg <= 1'b0;
      err_reg <= 1'b0;
      src_radio_reg <= 1'b0;
      cmd_reg <= 8'h00;
      addr_reg <= 8'h00;
      len_reg <= 8'h00;
      idx_reg <= 8'h00;
      out_idx_reg <= 4'h0;
    end else if (!cfg_mode) begin
      state_reg <= st_idle;
      wrap_reg <= 1'b0;
    end else if (state_reg == st_reply) begin
      if (reply_fire) begin
        out_idx_reg <= out_idx_reg + 4'h1;
        if (out_idx_reg == out_total - 4'h1) begin
          state_reg <= st_idle;
          wrap_reg <= 1'b0;
        end
      end
    end else if (p_valid) begin
      if (frame_free) src_radio_reg <= radio_in;
      err_reg <= 1'b0;
      out_idx_reg <= 4'h0;
      case (state_reg)
        st_idle: begin
          cmd_reg <= p_byte;
          if (p_byte == `MMCP_HDR_WRAP && !wrap_reg) begin
            state_reg <= st_wrap2;
          end else if (p_byte == `MMCP_HDR_WRITE || p_byte == `MMCP_HDR_READ ||
              p_byte == `MMCP_HDR_TEMP) begin
            state_reg <= st_addr;
          end else begin
            err_reg <= 1'b1;
            state_reg <= st_reply;
          end
        end
        st_wrap2: begin
          if (p_byte == `MMCP_HDR_WRAP) begin
            wrap_reg <= 1'b1;
            state_reg <= st_idle;
          end else begin
            err_reg <= 1'b1;
            state_reg <= st_reply;
          end
        end
        st_addr: begin
          addr_reg <= p_byte;
          state_reg <= st_len;
        end
        st_len: begin
          len_reg <= p_byte;
          idx_reg <= 8'h00;
          if (p_byte == 8'h00 || end_addr > `MMCP_REG_LIMIT) begin
            err_reg <= 1'b1;
            state_reg <= st_reply;
          end else if (cmd_reg == `MMCP_HDR_READ) begin
            state_reg <= st_reply;
          end else begin
            state_reg <= st_param;
          end
        end
        st_param: begin
          idx_reg <= idx_reg + 8'h01;
          if (idx_reg == len_reg - 8'h01) state_reg <= st_reply;
        end
        default: state_reg <= st_idle;
      endcase
    end
  end

  // ==========================================================
  // wishbone slave, one wait state, registered answer
  logic wb_req;
  logic wb_wr;
  logic [2:0] par_idx;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];
  assign par_idx = 3'(addr_reg[2:0] + idx_reg[2:0]);

  // register writes, parser ahead of the bus
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `MMCP_REG_COUNT; i++) cfg_reg[i] <= 8'h00;
      cfg_reg[`MMCP_RATE_IDX] <= `MMCP_RATE_RESET;
      sender_reg <= 1'b0;
    end else begin
      if (cfg_mode && p_valid && state_reg == st_param) begin
        cfg_reg[par_idx] <= p_byte;
      end else if (wb_wr && !wb_adr_i[5]) begin
        cfg_reg[wb_adr_i[4:2]] <= wb_dat_i[7:0];
      end
      if (wb_wr && wb_adr_i == `MMCP_WB_CTRL) sender_reg <= wb_dat_i[`MMCP_CTRL_SENDER];
    end
  end

  // acknowledge and read data
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        if (!wb_adr_i[5]) wb_dat_o <= {24'h000000, cfg_reg[wb_adr_i[4:2]]};
        else if (wb_adr_i == `MMCP_WB_STATUS)
          wb_dat_o <= {25'h0000000, rt_valid_reg, tx_busy_reg, state_reg, mode};
        else if (wb_adr_i == `MMCP_WB_CTRL) wb_dat_o <= {31'h00000000, sender_reg};
        else wb_dat_o <= 32'h00000000;
      end
    end
  end

  // ==========================================================
  // radio transmit holding register with wake preamble
  logic [15:0] pre_cnt_reg;
  logic relay_up;
  logic rt_load;
  logic [7:0] rt_byte;

  assign relay_up = data_mode && rx_valid_reg && !rt_valid_reg;
  assign rt_load = relay_up || (reply_fire && src_radio_reg);
  assign rt_byte = relay_up ? rx_byte_reg : reply_byte;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      radio_tx_data <= 8'h00;
      rt_valid_reg <= 1'b0;
      pre_cnt_reg <= 16'h0000;
    end else if (mode == mode_sleep) begin
      rt_valid_reg <= 1'b0;
      pre_cnt_reg <= 16'h0000;
    end else if (rt_load) begin
      radio_tx_data <= rt_byte;
      rt_valid_reg <= 1'b1;
      if (mode == mode_wor && sender_reg) pre_cnt_reg <= 16'(WAKE_CYCLES);
    end else if (pre_cnt_reg != 16'h0000) begin
      pre_cnt_reg <= pre_cnt_reg - 16'h0001;
    end else if (radio_tx_valid && radio_tx_ready) begin
      rt_valid_reg <= 1'b0;
    end
  end

  assign radio_tx_preamble = (pre_cnt_reg != 16'h0000);
  assign radio_tx_valid = rt_valid_reg && !radio_tx_preamble && (mode != mode_sleep);

  // ==========================================================
  // radio receive steering and serial transmit source
  always_comb begin
    case (mode)
      mode_transparent, mode_wor: radio_rx_ready = !tx_busy_reg;
      mode_config: radio_rx_ready = (state_reg != st_reply) &&
          (frame_free ? !rx_valid_reg : src_radio_reg);
      default: radio_rx_ready = 1'b0;
    endcase
  end

  assign tx_load = (data_mode && radio_rx_valid && !tx_busy_reg) ||
      (reply_fire && !src_radio_reg);
  assign tx_byte = data_mode ? radio_rx_data : reply_byte;

endmodule : mmcp_top

// file: bench/mmcp_checker.sv
// port-level assertions for the modem mode and configuration parser
module mmcp_checker
  import mmcp_pkg::*;
#(
  parameter int WAKE_CYCLES = 10000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // mode and serial
  input wire logic mode_select_low,
  input wire logic mode_select_high,
  input wire logic host_txd,
  // radio paths
  input wire logic [7:0] radio_tx_data,
  input wire logic radio_tx_valid,
  input wire logic radio_tx_ready,
  input wire logic radio_tx_preamble,
  input wire logic radio_rx_ready,
  input wire logic radio_rx_enable,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // helpers
  logic sleep_now;
  logic [3:0] sl_hist;
  int pre_cnt;
  assign sleep_now = mode_select_high && mode_select_low;
  // last four samples of the sleep selection
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sl_hist <= 4'h0;
    end else begin
      sl_hist <= {sl_hist[2:0], sleep_now};
    end
  end
  // cycles the preamble has stood high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_cnt <= 0;
    end else begin
      pre_cnt <= radio_tx_preamble ? pre_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // assertions
  chk_sleep_tx_off: assert property (&sl_hist && sleep_now |-> !radio_tx_valid)
    else $error("radio byte offered in deep sleep");
  chk_sleep_rx_off: assert property (&sl_hist && sleep_now |->
      !radio_rx_ready && !radio_rx_enable)
    else $error("receiver active in deep sleep");
  chk_awake_rx_on: assert property (sl_hist == 4'h0 && !sleep_now |-> radio_rx_enable)
    else $error("receiver off outside deep sleep");
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_rd_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_tx_hold: assert property (radio_tx_valid && !radio_tx_ready
      |=> sleep_now || (radio_tx_valid && $stable(radio_tx_data)))
    else $error("radio byte dropped before taken");
  chk_pre_quiet: assert property (radio_tx_preamble |-> !radio_tx_valid)
    else $error("byte offered during preamble");
  chk_pre_len: assert property ($fell(radio_tx_preamble) |-> pre_cnt == WAKE_CYCLES)
    else $error("preamble length wrong");
  chk_start_bit: assert property ($fell(host_txd) |-> !host_txd [*8])
    else $error("serial start bit too short");
  // ==========================================================
  // covers
  cov_preamble: cover property ($rose(radio_tx_preamble));
  cov_radio_tx: cover property (radio_tx_valid && radio_tx_ready);
  cov_wb_write: cover property (wb_ack_o && wb_we_i);
endmodule : mmcp_checker

bind mmcp_top mmcp_checker #(.WAKE_CYCLES(WAKE_CYCLES)) mmcp_checker_inst (
  .clk(clk), .rst_b(rst_b), .mode_select_low(mode_select_low),
  .mode_select_high(mode_select_high), .host_txd(host_txd),
  .radio_tx_data(radio_tx_data), .radio_tx_valid(radio_tx_valid),
  .radio_tx_ready(radio_tx_ready), .radio_tx_preamble(radio_tx_preamble),
  .radio_rx_ready(radio_rx_ready), .radio_rx_enable(radio_rx_enable),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
);

// file: bench/mmcp_host_model.sv
// host serial controller model on the parser's serial link
module mmcp_host_model (
  // clock and bit period in cycles
  input wire logic clk,
  input wire logic [31:0] div,
  // serial lines
  input wire logic host_txd,
  output logic host_rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rx_q[$];
  logic [7:0] b;
  // idle line is high
  initial host_rxd = 1'b1;
  // ==========================================================
  // send one byte 8n1, lsb first
  task automatic send_byte(input logic [7:0] d);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      host_rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i-1];
      repeat (div - 1) @(posedge clk);
    end
  endtask : send_byte
  // ==========================================================
  // collect device bytes at mid-bit, bad stop dropped
  always begin
    @(negedge host_txd);
    repeat (div / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge clk);
      b[i] = host_txd;
    end
    repeat (div) @(posedge clk);
    if (host_txd === 1'b1) rx_q.push_back(b);
  end
endmodule : mmcp_host_model

// file: bench/mmcp_top_tb.sv
// self-checking bench for the modem mode and configuration parser
`include "mmcp_params.svh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin errors++; \
  $display("unexpected %s expected %h seen %h", n, e, s); end end
module mmcp_top_tb
  import mmcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef logic [7:0] mmcp_bytes_type[$];
  logic clk = 1'b0, rst_b = 1'b0, msl = 1'b0, msh = 1'b0, host_rxd, host_txd;
  logic [7:0] tx_d, rx_d = 8'h00, mdl[8] = '{0, 0, 0, {3'h3, 5'h0}, 0, 0, 0, 0};
  logic tx_v, tx_r = 1'b0, pre, rx_v = 1'b0, rx_r, rx_en, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [31:0] wdat = 32'h0, rdat, q, d;
  logic ack;
  int errors = 0, check_count = 0, seed = 32'h9c04, hdiv = `MMCP_CLK_HZ / `MMCP_BAUD3;
  mmcp_bytes_type tq;
  // 10 mhz clock
  always #50 clk = ~clk;
  mmcp_top #(.WAKE_CYCLES(20)) mmcp_top_inst (
    .clk(clk), .rst_b(rst_b), .mode_select_low(msl), .mode_select_high(msh),
    .host_rxd(host_rxd), .host_txd(host_txd), .radio_tx_data(tx_d),
    .radio_tx_valid(tx_v), .radio_tx_ready(tx_r), .radio_tx_preamble(pre),
    .radio_rx_data(rx_d), .radio_rx_valid(rx_v), .radio_rx_ready(rx_r),
    .radio_rx_enable(rx_en), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
  mmcp_host_model mmcp_host_model_inst (
    .clk(clk), .div(hdiv), .host_txd(host_txd), .host_rxd(host_rxd));
  // radio sink with random stalls
  always @(posedge clk) begin
    if (tx_v === 1'b1 && tx_r === 1'b1) tq.push_back(tx_d);
    tx_r <= 1'($random(seed));
  end
  // ==========================================================
  // bus, radio and queue tasks
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] v);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= v;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rads(input mmcp_bytes_type c);
    foreach (c[i]) begin
      @(posedge clk);
      rx_d <= c[i];
      rx_v <= 1'b1;
      do @(posedge clk); while (rx_r !== 1'b1);
      rx_v <= 1'b0;
      rx_d <= ~c[i];
    end
  endtask : rads
  task automatic cmpq(ref mmcp_bytes_type g, input mmcp_bytes_type e);
    for (int i = 0; i < 50000 && g.size() < e.size(); i++) @(posedge clk);
    `CHK("byte count", e.size(), g.size())
    foreach (e[i]) if (i < g.size()) `CHK("byte", e[i], g[i])
    g.delete();
  endtask : cmpq
  task automatic set_mode(input mmcp_mode_type m);
    @(posedge clk);
    {msh, msl} <= m;
    repeat (4) @(posedge clk);
  endtask : set_mode
  // expected reply from the bench's own register model
  function automatic mmcp_bytes_type want(mmcp_bytes_type c);
    mmcp_bytes_type r;
    int p, a, n;
    p = (c[0] == 8'hcf) ? 2 : 0;
    if (p == 2) r = '{8'hcf, 8'hcf};
    a = c[p+1];
    n = c[p+2];
    if (!(c[p] inside {8'hc0, 8'hc1, 8'hc2}) || n == 0 || a + n > 8)
      return {r, 8'hff, 8'hff, 8'hff};
    if (c[p] != 8'hc1) for (int i = 0; i < n; i++) mdl[a+i] = c[p+3+i];
    r = {r, 8'hc1, c[p+1], c[p+2]};
    for (int i = 0; i < n; i++) r.push_back(mdl[a+i]);
    return r;
  endfunction : want
  task automatic cfg(input mmcp_bytes_type c);
    rads(c);
    cmpq(tq, want(c));
  endtask : cfg
  task automatic end_sim;
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  // watchdog
  initial begin
    repeat (80000) @(posedge clk);
    errors++;
    end_sim();
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      wb(1'b0, 6'(4 * i), 32'h0);
      `CHK("reset byte", {24'h0, mdl[i]}, q)
    end
    wb(1'b0, 6'h28, 32'h0);
    `CHK("unmapped", 32'h0, q)
    for (int m = 0; m < 4; m++) begin
      set_mode(mmcp_mode_type'(m));
      wb(1'b0, `MMCP_WB_STATUS, 32'h0);
      `CHK("mode", 2'(m), q[1:0])
    end
    set_mode(mode_config);
    d = $random(seed);
    cfg('{8'hc0, 8'h00, 8'h02, d[15:8], d[7:0]});
    cfg('{8'hcf, 8'hcf, 8'hc2, 8'h02, 8'h01, d[23:16]});
    cfg('{8'hcf, 8'hcf, 8'hc1, 8'h00, 8'h03});
    cfg('{8'h55});
    cfg('{8'hc1, 8'h00, 8'h00});
    cfg('{8'hc1, 8'h07, 8'h02});
    wb(1'b0, 6'h08, 32'h0);
    `CHK("net id", {24'h0, mdl[2]}, q)
    rads('{8'hc0, 8'h00});
    set_mode(mode_transparent);
    set_mode(mode_config);
    cfg('{8'hc1, 8'h00, 8'h01});
    wb(1'b1, 6'h0c, 32'he0);
    mmcp_host_model_inst.send_byte(8'h55);
    cmpq(mmcp_host_model_inst.rx_q, '{8'hff, 8'hff, 8'hff});
    hdiv = `MMCP_CLK_HZ / `MMCP_BAUD7;
    wb(1'b1, `MMCP_WB_CTRL, 32'h1);
    for (int k = 0; k < 2; k++) begin
      set_mode(mmcp_mode_type'(k));
      d = $random(seed);
      mmcp_host_model_inst.send_byte(d[7:0]);
      cmpq(tq, '{d[7:0]});
      rads('{d[15:8]});
      cmpq(mmcp_host_model_inst.rx_q, '{d[15:8]});
    end
    set_mode(mode_sleep);
    mmcp_host_model_inst.send_byte(d[23:16]);
    repeat (1000) @(posedge clk);
    `CHK("sleep tx", 0, tq.size())
    `CHK("sleep rx", 1'b0, rx_en)
    end_sim();
  end
endmodule : mmcp_top_tb
